// [can_channel_irq_and_filter_regs.v]
`default_nettype none
`include "can_chan_defs.vh"

module can_channel_irq_and_filter_regs #(
    parameter NCH = 32,
    parameter CH_W = 5
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // register port
    input wire [`ADDR_W-1:0] addr_i,
    input wire [`DATA_W-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [`DATA_W-1:0] rdata_o,
    // interrupt
    output reg irq_o,
    // events from the protocol engine
    input wire [NCH-1:0] chan_event_i,
    // received frame from the protocol engine
    input wire rx_valid_i,
    input wire [CH_W-1:0] rx_chan_i,
    input wire rx_ide_i,
    input wire [28:0] rx_tag_i,
    input wire [1:0] rx_rb_i,
    input wire rx_rtr_i,
    input wire [63:0] rx_data_i,
    output reg rx_accept_o,
    // transmit tag request from the protocol engine
    input wire tx_req_i,
    input wire [CH_W-1:0] tx_chan_i,
    output reg tx_valid_o,
    output reg tx_ide_o,
    output reg [28:0] tx_tag_o,
    output reg [1:0] tx_rb_o,
    output reg tx_rtr_o
);

localparam [`ADDR_W-1:0] CHAN_END = `OFS_CHAN_BASE + (NCH << `CHAN_STRIDE_LOG2);

// channel window decode, used by the write and the read path
function chan_hit;
    input [`ADDR_W-1:0] a;
    begin
        chan_hit = (a >= `OFS_CHAN_BASE) && (a < CHAN_END);
    end
endfunction

function [CH_W-1:0] chan_of;
    input [`ADDR_W-1:0] a;
    reg [`ADDR_W-1:0] rel;
    begin
        rel = a - `OFS_CHAN_BASE;
        chan_of = rel[`CHAN_STRIDE_LOG2+CH_W-1:`CHAN_STRIDE_LOG2];
    end
endfunction

function [2:0] word_of;
    input [`ADDR_W-1:0] a;
    begin
        word_of = a[4:2];
    end
endfunction

reg [NCH-1:0] src_q;
reg [NCH-1:0] src_d;
reg [NCH-1:0] en_q;
reg [NCH-1:0] en_d;
reg [31:0] accept_mask_q [0:NCH-1];
reg [31:0] frame_tag_q [0:NCH-1];
reg [NCH-1:0] extended_q;
reg [`DATA_W-1:0] reg_rdata_q;
reg [`DATA_W-1:0] reg_rdata_d;
reg rd_mem_q;
reg rd_hi_q;
reg [NCH-1:0] accept_set;

wire wr_chan;
wire [CH_W-1:0] wr_ch;
wire [2:0] wr_word;
wire rd_chan;
wire [CH_W-1:0] rd_ch;
wire [2:0] rd_word;
wire rx_match;
wire rx_take;
wire sw_lo;
wire sw_hi;
wire mem_we_lo;
wire mem_we_hi;
wire [CH_W-1:0] mem_waddr;
wire [63:0] mem_wdata;
wire [63:0] mem_rdata;
wire [NCH-1:0] src_clr;
integer i;

assign wr_chan = wr_i && chan_hit(addr_i) && (addr_i[1:0] == 2'b00);
assign wr_ch = chan_of(addr_i);
assign wr_word = word_of(addr_i);
assign rd_chan = chan_hit(addr_i) && (addr_i[1:0] == 2'b00);
assign rd_ch = chan_of(addr_i);
assign rd_word = word_of(addr_i);

// acceptance check against the addressed channel's setup
tag_filter u_filter (
    .accept_mask_i(accept_mask_q[rx_chan_i]),
    .frame_tag_i(frame_tag_q[rx_chan_i]),
    .extended_i(extended_q[rx_chan_i]),
    .rx_ide_i(rx_ide_i),
    .rx_tag_i(rx_tag_i),
    .rx_rb_i(rx_rb_i),
    .rx_rtr_i(rx_rtr_i),
    .match_o(rx_match)
);

assign rx_take = rx_valid_i && rx_match;

// a received frame wins the single write port; a colliding software write is lost
assign sw_lo = wr_chan && (wr_word == `CHAN_WORD_PAYLOAD_LOW);
assign sw_hi = wr_chan && (wr_word == `CHAN_WORD_PAYLOAD_HIGH);
assign mem_we_lo = rx_take | sw_lo;
assign mem_we_hi = rx_take | sw_hi;
assign mem_waddr = rx_take ? rx_chan_i : wr_ch;
// byte 0 sits in the lowest lane of the low word, byte 4 in the lowest lane of the high word
assign mem_wdata = rx_take ? rx_data_i : {wdata_i, wdata_i};

chan_payload_mem #(
    .W(64),
    .D(NCH),
    .AW(CH_W)
) u_payload (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_lo_i(mem_we_lo),
    .we_hi_i(mem_we_hi),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(rd_ch),
    .rdata_o(mem_rdata)
);

always @*
begin
    accept_set = {NCH{1'b0}};
    if (rx_take)
    begin
        accept_set[rx_chan_i] = 1'b1;
    end
end

assign src_clr = (wr_i && (addr_i == `OFS_IRQ_CLEAR)) ? wdata_i[NCH-1:0] : {NCH{1'b0}};

// a new event in the clearing cycle survives
always @*
begin
    src_d = (src_q & ~src_clr) | chan_event_i | accept_set;
    en_d = en_q;
    if (wr_i && (addr_i == `OFS_IRQ_ENABLE))
    begin
        en_d = en_q | wdata_i[NCH-1:0];
    end
    if (wr_i && (addr_i == `OFS_IRQ_DISABLE))
    begin
        en_d = en_q & ~wdata_i[NCH-1:0];
    end
end

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        src_q <= {NCH{1'b0}};
        en_q <= {NCH{1'b0}};
        irq_o <= 1'b0;
        rx_accept_o <= 1'b0;
    end
    else
    begin
        src_q <= src_d;
        en_q <= en_d;
        irq_o <= |(src_d & en_d);
        rx_accept_o <= rx_take;
    end
end

// channel setup registers
always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        extended_q <= {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1)
        begin
            accept_mask_q[i] <= `RST_WORD;
            frame_tag_q[i] <= `RST_WORD;
        end
    end
    else if (wr_chan)
    begin
        case (wr_word)
            `CHAN_WORD_ACCEPT_MASK:
            begin
                accept_mask_q[wr_ch] <= wdata_i;
            end
            `CHAN_WORD_FRAME_TAG:
            begin
                frame_tag_q[wr_ch] <= wdata_i;
            end
            `CHAN_WORD_CONFIG:
            begin
                extended_q[wr_ch] <= wdata_i[`BIT_CFG_EXTENDED];
            end
            default:
            begin
                extended_q <= extended_q;
            end
        endcase
    end
end

// transmit tag: a standard channel puts out only its base bits
always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        tx_valid_o <= 1'b0;
        tx_ide_o <= 1'b0;
        tx_tag_o <= 29'h0;
        tx_rb_o <= 2'h0;
        tx_rtr_o <= 1'b0;
    end
    else
    begin
        tx_valid_o <= tx_req_i;
        if (tx_req_i)
        begin
            tx_ide_o <= extended_q[tx_chan_i];
            tx_tag_o <= extended_q[tx_chan_i] ? frame_tag_q[tx_chan_i][`FLD_TAG_HI:0] :
                {18'h0, frame_tag_q[tx_chan_i][`FLD_BASE_TAG_HI:0]};
            tx_rb_o <= frame_tag_q[tx_chan_i][`FLD_RESERVED_CTRL_HI:`FLD_RESERVED_CTRL_LO];
            tx_rtr_o <= frame_tag_q[tx_chan_i][`BIT_REMOTE_REQ];
        end
    end
end

// register read mux; payload words come out of the memory a cycle later
always @*
begin
    reg_rdata_d = `RST_WORD;
    if (rd_chan)
    begin
        case (rd_word)
            `CHAN_WORD_ACCEPT_MASK:
            begin
                reg_rdata_d = accept_mask_q[rd_ch];
            end
            `CHAN_WORD_FRAME_TAG:
            begin
                reg_rdata_d = frame_tag_q[rd_ch];
            end
            `CHAN_WORD_CONFIG:
            begin
                reg_rdata_d[`BIT_CFG_EXTENDED] = extended_q[rd_ch];
            end
            default:
            begin
                reg_rdata_d = `RST_WORD;
            end
        endcase
    end
    else
    begin
        case (addr_i)
            `OFS_GLOBAL_STATUS:
            begin
                reg_rdata_d[`BIT_ANY_CHANNEL_PENDING] = |src_q;
            end
            `OFS_IRQ_SOURCE:
            begin
                reg_rdata_d[NCH-1:0] = src_q;
            end
            `OFS_IRQ_MASK:
            begin
                reg_rdata_d[NCH-1:0] = en_q;
            end
            default:
            begin
                reg_rdata_d = `RST_WORD;
            end
        endcase
    end
end

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        reg_rdata_q <= `RST_WORD;
        rd_mem_q <= 1'b0;
        rd_hi_q <= 1'b0;
    end
    else
    begin
        reg_rdata_q <= rd_i ? reg_rdata_d : `RST_WORD;
        rd_mem_q <= rd_i && rd_chan && (rd_word[2:1] == 2'b00);
        rd_hi_q <= rd_word[0];
    end
end

// both sources are registers; only the select is applied after the flops
assign rdata_o = rd_mem_q ? (rd_hi_q ? mem_rdata[63:32] : mem_rdata[31:0]) : reg_rdata_q;

endmodule // can_channel_irq_and_filter_regs

`default_nettype wire

// [can_chan_defs.vh]
`ifndef CAN_CHAN_DEFS_VH
`define CAN_CHAN_DEFS_VH

// register bus
`define ADDR_W 12
`define DATA_W 32

// global register byte addresses
`define OFS_GLOBAL_STATUS 12'h070
`define OFS_IRQ_CLEAR 12'h080
`define OFS_IRQ_SOURCE 12'h084
`define OFS_IRQ_ENABLE 12'h088
`define OFS_IRQ_DISABLE 12'h08c
`define OFS_IRQ_MASK 12'h090

// per-channel window: base + channel * stride + word * 4
`define OFS_CHAN_BASE 12'h100
`define CHAN_STRIDE_LOG2 5
`define CHAN_WORD_PAYLOAD_LOW 3'h0
`define CHAN_WORD_PAYLOAD_HIGH 3'h1
`define CHAN_WORD_ACCEPT_MASK 3'h2
`define CHAN_WORD_FRAME_TAG 3'h3
`define CHAN_WORD_CONFIG 3'h4

// global status field
`define BIT_ANY_CHANNEL_PENDING 7

// acceptance mask and frame tag layout
`define BIT_REMOTE_REQ 31
`define FLD_RESERVED_CTRL_HI 30
`define FLD_RESERVED_CTRL_LO 29
`define FLD_TAG_HI 28
`define FLD_BASE_TAG_HI 10
`define FLD_EXT_TAG_LO 11

// channel config field
`define BIT_CFG_EXTENDED 0

// reset values
`define RST_WORD 32'h0000_0000
`define RST_PAYLOAD 64'h0000_0000_0000_0000

`endif

// [chan_payload_mem.v]
`default_nettype none

// two write lanes so that software can update one half without a read-modify-write
module chan_payload_mem #(
    parameter W = 64,
    parameter D = 32,
    parameter AW = 5
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // write port
    input wire we_lo_i,
    input wire we_hi_i,
    input wire [AW-1:0] waddr_i,
    input wire [W-1:0] wdata_i,
    // read port
    input wire [AW-1:0] raddr_i,
    output reg [W-1:0] rdata_o
);

reg [W-1:0] mem_q [0:D-1];

always @(posedge clk_i)
begin
    if (we_lo_i)
    begin
        mem_q[waddr_i][W/2-1:0] <= wdata_i[W/2-1:0];
    end
    if (we_hi_i)
    begin
        mem_q[waddr_i][W-1:W/2] <= wdata_i[W-1:W/2];
    end
end

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        rdata_o <= {W{1'b0}};
    end
    else
    begin
        rdata_o <= mem_q[raddr_i];
    end
end

endmodule // chan_payload_mem

`default_nettype wire

// [tag_filter.v]
`default_nettype none
`include "can_chan_defs.vh"

// a mask bit of one means the received bit must equal the stored bit
module tag_filter (
    // channel setup
    input wire [31:0] accept_mask_i,
    input wire [31:0] frame_tag_i,
    input wire extended_i,
    // received frame
    input wire rx_ide_i,
    input wire [28:0] rx_tag_i,
    input wire [1:0] rx_rb_i,
    input wire rx_rtr_i,
    // result
    output wire match_o
);

wire [28:0] tag_mask;
wire [28:0] tag_diff;
wire [1:0] rb_mask;
wire [1:0] rb_diff;
wire rtr_bad;
wire fmt_bad;

// standard channels ignore the upper mask bits and the upper reserved bit
assign tag_mask = extended_i ? accept_mask_i[`FLD_TAG_HI:0] :
    {18'h0, accept_mask_i[`FLD_BASE_TAG_HI:0]};
assign tag_diff = (frame_tag_i[`FLD_TAG_HI:0] ^ rx_tag_i) & tag_mask;
assign rb_mask = {accept_mask_i[`FLD_RESERVED_CTRL_HI] & extended_i,
    accept_mask_i[`FLD_RESERVED_CTRL_LO]};
assign rb_diff = (frame_tag_i[`FLD_RESERVED_CTRL_HI:`FLD_RESERVED_CTRL_LO] ^ rx_rb_i) & rb_mask;
assign rtr_bad = accept_mask_i[`BIT_REMOTE_REQ] &
    (frame_tag_i[`BIT_REMOTE_REQ] ^ rx_rtr_i);
assign fmt_bad = rx_ide_i ^ extended_i;
assign match_o = ~fmt_bad & ~rtr_bad & ~|rb_diff & ~|tag_diff;

endmodule // tag_filter

`default_nettype wire

// [can_chan_monitor.sv]
`default_nettype none
module can_chan_monitor (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // register port and events
    input wire [11:0] addr_i,
    input wire wr_i,
    input wire [31:0] rdata_o,
    input wire rd_i,
    input wire irq_o,
    input wire [31:0] chan_event_i,
    input wire rx_valid_i,
    input wire rx_accept_o,
    // transmit side
    input wire tx_req_i,
    input wire tx_valid_o,
    input wire tx_ide_o,
    input wire [28:0] tx_tag_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_tx_ans;
        tx_req_i |=> tx_valid_o;
    endproperty
    a_tx_ans: assert property (p_tx_ans) else $error("no tx answer");
    property p_tx_idle;
        !tx_req_i |=> !tx_valid_o && $stable(tx_tag_o);
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("tx moved unasked");
    property p_std_tag;
        tx_valid_o && !tx_ide_o |-> tx_tag_o[28:11] == 18'h0;
    endproperty
    a_std_tag: assert property (p_std_tag) else $error("std tag upper set");
    property p_acc;
        rx_accept_o |-> $past(rx_valid_i);
    endproperty
    a_acc: assert property (p_acc) else $error("accept without frame");
    property p_acc_one;
        rx_accept_o |=> !rx_accept_o || $past(rx_valid_i);
    endproperty
    a_acc_one: assert property (p_acc_one) else $error("accept stretched");
    property p_irq_up;
        $rose(irq_o) |-> $past(chan_event_i) != 32'h0 || $past(rx_valid_i) || $past(wr_i);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose alone");
    property p_irq_dn;
        $fell(irq_o) |-> $past(wr_i) && ($past(addr_i) == 12'h080 || $past(addr_i) == 12'h08c);
    endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell alone");
    property p_wo_rd;
        rd_i && addr_i == 12'h088 |=> rdata_o == 32'h0;
    endproperty
    a_wo_rd: assert property (p_wo_rd) else $error("enable reg readable");
endmodule // can_chan_monitor
`default_nettype wire

// [can_node_model.sv]
`default_nettype none
module can_node_model (
    input wire logic clk_i,
    output logic valid_o,
    output logic [4:0] chan_o,
    output logic ide_o,
    output logic [28:0] tag_o,
    output logic [1:0] rb_o,
    output logic rtr_o,
    output logic [63:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        valid_o = 1'b0;
        chan_o = 5'h0;
        ide_o = 1'b0;
        tag_o = 29'h0;
        rb_o = 2'h0;
        rtr_o = 1'b0;
        data_o = 64'h0;
    end
    task automatic send(input [4:0] c, input x, input [28:0] t, input [1:0] b, input r,
        input [63:0] d);
        @(posedge clk_i);
        valid_o <= 1'b1;
        chan_o <= c;
        ide_o <= x;
        tag_o <= t;
        rb_o <= b;
        rtr_o <= r;
        data_o <= d;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // stale fields must not look like a frame
        tag_o <= ~t;
        data_o <= ~d;
    endtask
endmodule // can_node_model
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] addr_i = 12'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] chan_event_i = 32'h0;
    logic tx_req_i = 1'b0;
    logic [4:0] tx_chan_i = 5'h0;
    wire [31:0] rdata_o;
    wire irq_o, rx_accept_o, tx_valid_o, tx_ide_o, tx_rtr_o, rv, ri, rr;
    wire [28:0] tx_tag_o, rt;
    wire [1:0] tx_rb_o, rb;
    wire [4:0] rc;
    wire [63:0] rd;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int seed = 72322;
    logic [31:0] m_src = 0, m_msk = 0, r;
    logic [63:0] pay;
    can_channel_irq_and_filter_regs u_can_channel_irq_and_filter_regs (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .chan_event_i(chan_event_i), .rx_valid_i(rv),
        .rx_chan_i(rc), .rx_ide_i(ri), .rx_tag_i(rt), .rx_rb_i(rb), .rx_rtr_i(rr),
        .rx_data_i(rd), .rx_accept_o(rx_accept_o), .tx_req_i(tx_req_i), .tx_chan_i(tx_chan_i),
        .tx_valid_o(tx_valid_o), .tx_ide_o(tx_ide_o), .tx_tag_o(tx_tag_o), .tx_rb_o(tx_rb_o),
        .tx_rtr_o(tx_rtr_o));
    can_node_model u_can_node_model (.clk_i(clk_i), .valid_o(rv), .chan_o(rc), .ide_o(ri),
        .tag_o(rt), .rb_o(rb), .rtr_o(rr), .data_o(rd));
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    task automatic chk(input string n, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdc(input [11:0] a, input [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, rdata_o);
    endtask
    function automatic [11:0] ca(input [4:0] c, input [2:0] w);
        ca = 12'h100 + {2'b0, c, 5'h0} + {7'h0, w, 2'b0};
    endfunction
    task automatic irq_src;
        #1 chk("irq", {31'h0, |(m_src & m_msk)}, {31'h0, irq_o});
        rdc(12'h084, m_src);
        rdc(12'h070, {24'h0, |m_src, 7'h0});
    endtask
    task automatic frame(input [4:0] c, input x, input [28:0] t, input [1:0] b, input q,
        input e);
        pay = {$random(seed), $random(seed)};
        u_can_node_model.send(c, x, t, b, q, pay);
        #1 chk("accept", {31'h0, e}, {31'h0, rx_accept_o});
        if (e)
        begin
            m_src[c] = 1'b1;
            rdc(ca(c, 0), pay[31:0]);
            rdc(ca(c, 1), pay[63:32]);
        end
    endtask
    // f holds the expected {remote request, reserved bits, extended flag}
    task automatic tx(input [4:0] c, input [28:0] e, input [3:0] f);
        @(posedge clk_i);
        tx_req_i <= 1'b1;
        tx_chan_i <= c;
        @(posedge clk_i);
        tx_req_i <= 1'b0;
        #1 chk("tx_tag", {2'h0, 1'b1, e}, {2'h0, tx_valid_o, tx_tag_o});
        chk("tx_ctl", {28'h0, f}, {28'h0, tx_rtr_o, tx_rb_o, tx_ide_o});
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        irq_src;
        rdc(12'h090, 32'h0);
        rdc(12'h088, 32'h0);
        rdc(12'h0f0, 32'h0);
        $display("test reset done");
        r = $random(seed);
        wr(12'h088, r);
        m_msk |= r;
        r = $random(seed);
        wr(12'h08c, r);
        m_msk &= ~r;
        wr(12'h090, ~m_msk);
        rdc(12'h090, m_msk);
        repeat (4)
        begin
            r = $random(seed);
            @(posedge clk_i);
            chan_event_i <= r;
            @(posedge clk_i);
            chan_event_i <= 32'h0;
            m_src |= r;
            irq_src;
            r = $random(seed);
            wr(12'h080, r);
            m_src &= ~r;
            irq_src;
        end
        $display("test irq done");
        r = $random(seed);
        wr(ca(9, 0), r);
        rdc(ca(9, 0), r);
        wr(12'h088, 32'h24);
        m_msk |= 32'h24;
        wr(ca(2, 2), 32'hffff_ffff);
        wr(ca(2, 3), 32'h1fff_f955);
        frame(2, 0, 29'h0aaa_a955, 2'b10, 0, 1);
        frame(2, 0, 29'h154, 0, 0, 0);
        frame(2, 0, 29'h155, 0, 1, 0);
        frame(2, 1, 29'h1fff_f955, 0, 0, 0);
        wr(ca(2, 2), 32'h7fff_ffff);
        frame(2, 0, 29'h155, 0, 1, 1);
        tx(2, 29'h155, 4'h0);
        wr(ca(5, 4), 32'h1);
        wr(ca(5, 2), 32'hffff_ffff);
        wr(ca(5, 3), 32'h1234_5678);
        frame(5, 1, 29'h1234_5e78, 0, 0, 0);
        frame(5, 1, 29'h1234_5678, 2'b10, 0, 0);
        frame(5, 1, 29'h1234_5678, 0, 0, 1);
        irq_src;
        // filter tests are over, so the tag may now carry remote request and reserved bits
        wr(ca(5, 3), 32'hd234_5678);
        tx(5, 29'h1234_5678, 4'hd);
        $display("test filter done");
        tally_and_finish;
    end
endmodule // tb_top
bind can_channel_irq_and_filter_regs can_chan_monitor u_mon (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rdata_o(rdata_o), .rd_i(rd_i),
    .irq_o(irq_o), .chan_event_i(chan_event_i), .rx_valid_i(rx_valid_i),
    .rx_accept_o(rx_accept_o), .tx_req_i(tx_req_i), .tx_valid_o(tx_valid_o),
    .tx_ide_o(tx_ide_o), .tx_tag_o(tx_tag_o));
`default_nettype wire
